// ### logic/rx_hf_consts.vh
`ifndef RX_HF_CONSTS_VH
`define RX_HF_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ADDR_W              8
`define OFF_HF_CTRL         8'h00
`define OFF_SLOT_MASK       8'h04
`define OFF_BIT_CTRL        8'h08
`define OFF_STATUS          8'h0C

// ----------------------------------------------------------------
// High-frequency clock control fields
// ----------------------------------------------------------------
`define HF_SRC_BIT          15
`define HF_INV_BIT          14
`define HF_RATIO_MSB        11
`define HF_RATIO_W          12
`define HF_CTRL_RESET       32'h00008000
`define HF_CTRL_WMASK       32'h0000CFFF

// ----------------------------------------------------------------
// Bit clock control fields
// ----------------------------------------------------------------
`define BC_SRC_BIT          5
`define BC_RATIO_MSB        4
`define BC_RATIO_W          5
`define BIT_CTRL_RESET      32'h00000000
`define BIT_CTRL_WMASK      32'h0000003F

// ----------------------------------------------------------------
// Slot mask and status fields
// ----------------------------------------------------------------
`define SLOT_MASK_RESET     32'h00000000
`define SLOT_W              5
`define SLOT_BITS_DEFAULT   32
`define ST_SLOT_LSB         0
`define ST_SLOT_MSB         4
`define ST_ACTIVE_BIT       8
`define ST_HF_LEVEL_BIT     9
`define ST_BCLK_LEVEL_BIT   10

`endif

// ### logic/clock_level_divider.v
`timescale 1ns/10ps
`default_nettype none

// Divides a sampled clock level by ratio + 1, near 50 % duty.
// Ratio zero passes the level through, one core cycle late.
module clock_level_divider #(
    parameter RATIO_W = 12
) (
    // Clock and reset
    input  wire               core_clk_in,
    input  wire               rst_n_in,
    // Source level and ratio
    input  wire               src_level_in,
    input  wire [RATIO_W-1:0] ratio_in,
    // Divided level
    output wire               div_level_out
);

    reg               prev_q;
    reg [RATIO_W-1:0] cnt_q;
    reg [RATIO_W-1:0] cnt_d;
    reg               out_q;
    reg               out_d;
    wire              rise;
    wire [RATIO_W:0]  half;

    assign rise = src_level_in & ~prev_q;
    // High for the first half of the output period, rounded up
    assign half = ({1'b0, ratio_in} + {{(RATIO_W-1){1'b0}}, 2'b10}) >> 1;

    // ------------------------------------------------------------
    // Next count and output level
    // ------------------------------------------------------------
    always @* begin
        cnt_d = cnt_q;
        if (rise) begin
            if (cnt_q >= ratio_in)
                cnt_d = {RATIO_W{1'b0}};
            else
                cnt_d = cnt_q + {{(RATIO_W-1){1'b0}}, 1'b1};
        end
        if (ratio_in == {RATIO_W{1'b0}})
            out_d = src_level_in;  // Divide-by-1 passes the level
        else
            out_d = ({1'b0, cnt_d} < half);
    end

    // Counting source rising edges keeps the ratio exact for any duty in
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_q <= 1'b0;
            cnt_q  <= {RATIO_W{1'b0}};
            out_q  <= 1'b0;
        end else begin
            prev_q <= src_level_in;
            cnt_q  <= cnt_d;
            out_q  <= out_d;
        end
    end

    assign div_level_out = out_q;

endmodule // clock_level_divider

`default_nettype wire

// ### logic/rx_hf_clock_and_slot_select.v
// Functional notes
// - Bit 15 picks external pin or divider
// - Bit 14 inverts clock before bit divider
// - Internal bit clock ratio zero passes through
// - Auxiliary clock divided by field plus one
// - Reserved control bits read zero, ignore writes
// - Set mask bit: shift data in slot
// - Clear mask bit: slot inactive, no capture
// - Bit divider divides by ratio plus one
// - Bit 5 picks external pin or internal divider

`timescale 1ns/10ps
`default_nettype none
`include "rx_hf_consts.vh"

module rx_hf_clock_and_slot_select #(
    parameter SLOT_BITS = `SLOT_BITS_DEFAULT
) (
    // Clock and reset
    input  wire        core_clk_in,
    input  wire        rst_n_in,
    // Register port
    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output wire [31:0] reg_rdata_out,
    // Clock sources
    input  wire        auxiliary_source_clock_in,
    input  wire        rx_hf_master_clock_in,
    output wire        rx_hf_master_clock_out,
    output wire        rx_hf_master_clock_oe_n_out,
    // Receive bit clock pin
    input  wire        rx_bit_clock_in,
    output wire        rx_bit_clock_out,
    output wire        rx_bit_clock_oe_n_out,
    // Frame and serial data
    input  wire        frame_sync_in,
    input  wire        serial_data_in,
    // Received words
    output wire [31:0] rx_word_out,
    output wire [4:0]  rx_word_slot_out,
    output wire        rx_word_valid_out,
    output wire        rx_slot_active_bit_out
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [31:0] rx_hf_clock_control_q;
    reg [31:0] rx_slot_enable_mask_q;
    reg [31:0] rx_bit_clock_control_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;

    // Clock path
    wire        rx_hf_clock_source_sel;
    wire        rx_hf_clock_invert;
    wire [11:0] rx_hf_clock_ratio;
    wire        rx_bit_clock_source_sel;
    wire [4:0]  rx_bit_clock_ratio;
    wire        hf_div_level;
    wire        hf_level;
    wire        hf_pol_level;
    wire        bit_div_level;
    reg         hf_out_q;
    reg         hf_oe_n_q;
    reg         bclk_out_q;
    reg         bclk_oe_n_q;
    reg         bclk_int_d;
    reg         bclk_d;

    // Slot path
    reg         bclk_prev_q;
    wire        bclk_rise;
    reg [4:0]   slot_q;
    reg [4:0]   slot_d;
    reg [4:0]   bit_q;
    reg [4:0]   bit_d;
    reg [31:0]  shift_q;
    reg [31:0]  shift_d;
    reg [31:0]  word_q;
    reg [4:0]   word_slot_q;
    reg         word_valid_q;
    reg         slot_active_q;
    wire        cur_active;
    wire        last_bit;

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    // New ratios act at once; a count above a smaller ratio wraps next rise
    assign rx_hf_clock_source_sel  = rx_hf_clock_control_q[`HF_SRC_BIT];
    assign rx_hf_clock_invert      = rx_hf_clock_control_q[`HF_INV_BIT];
    assign rx_hf_clock_ratio       = rx_hf_clock_control_q[`HF_RATIO_MSB:0];
    assign rx_bit_clock_source_sel = rx_bit_clock_control_q[`BC_SRC_BIT];
    assign rx_bit_clock_ratio      = rx_bit_clock_control_q[`BC_RATIO_MSB:0];

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Write masks keep reserved bits at zero whatever is written
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_hf_clock_control_q  <= `HF_CTRL_RESET;
            rx_slot_enable_mask_q  <= `SLOT_MASK_RESET;
            rx_bit_clock_control_q <= `BIT_CTRL_RESET;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `OFF_HF_CTRL: begin
                    rx_hf_clock_control_q <= reg_wdata_in & `HF_CTRL_WMASK;
                end
                `OFF_SLOT_MASK: begin
                    rx_slot_enable_mask_q <= reg_wdata_in;
                end
                `OFF_BIT_CTRL: begin
                    rx_bit_clock_control_q <= reg_wdata_in & `BIT_CTRL_WMASK;
                end
                default: begin
                    rx_slot_enable_mask_q <= rx_slot_enable_mask_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Data stand only in the cycle after the strobe; unmapped reads zero
    always @* begin
        rdata_d = 32'h00000000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `OFF_HF_CTRL: begin
                    rdata_d = rx_hf_clock_control_q & `HF_CTRL_WMASK;
                end
                `OFF_SLOT_MASK: begin
                    rdata_d = rx_slot_enable_mask_q;
                end
                `OFF_BIT_CTRL: begin
                    rdata_d = rx_bit_clock_control_q & `BIT_CTRL_WMASK;
                end
                `OFF_STATUS: begin
                    rdata_d[`ST_SLOT_MSB:`ST_SLOT_LSB] = slot_q;
                    rdata_d[`ST_ACTIVE_BIT]             = slot_active_q;
                    rdata_d[`ST_HF_LEVEL_BIT]           = hf_pol_level;
                    rdata_d[`ST_BCLK_LEVEL_BIT]         = bclk_prev_q;
                end
                default: begin
                    rdata_d = 32'h00000000;
                end
            endcase
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= rdata_d;
    end

    // ------------------------------------------------------------
    // High-frequency clock generation
    // ------------------------------------------------------------
    // Auxiliary level divided by ratio + 1 (0 = /1, max = /4096)
    clock_level_divider #(
        .RATIO_W (`HF_RATIO_W)
    ) u_hf_div (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .src_level_in  (auxiliary_source_clock_in),
        .ratio_in      (rx_hf_clock_ratio),
        .div_level_out (hf_div_level)
    );

    // Source select, then optional inversion ahead of the bit divider
    assign hf_level     = rx_hf_clock_source_sel ? hf_div_level
                                                 : rx_hf_master_clock_in;
    assign hf_pol_level = hf_level ^ rx_hf_clock_invert;

    // Pin is driven only while the clock is made inside
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hf_out_q  <= 1'b0;
            hf_oe_n_q <= 1'b1;
        end else begin
            hf_out_q  <= hf_div_level;
            hf_oe_n_q <= ~rx_hf_clock_source_sel;
        end
    end

    // ------------------------------------------------------------
    // Bit clock generation
    // ------------------------------------------------------------
    clock_level_divider #(
        .RATIO_W (`BC_RATIO_W)
    ) u_bit_div (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .src_level_in  (hf_pol_level),
        .ratio_in      (rx_bit_clock_ratio),
        .div_level_out (bit_div_level)
    );

    // Divide-by-1 bypasses the divider so no extra lag is added
    always @* begin
        if (rx_bit_clock_ratio == 5'h00)
            bclk_int_d = hf_pol_level;
        else
            bclk_int_d = bit_div_level;
        if (rx_bit_clock_source_sel)
            bclk_d = bclk_int_d;
        else
            bclk_d = rx_bit_clock_in;
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bclk_out_q  <= 1'b0;
            bclk_oe_n_q <= 1'b1;
        end else begin
            bclk_out_q  <= bclk_int_d;
            bclk_oe_n_q <= ~rx_bit_clock_source_sel;
        end
    end

    // ------------------------------------------------------------
    // Slot tracking and capture
    // ------------------------------------------------------------
    // Edges are found on sampled levels: a bit clock faster than half
    // the core clock loses rises, so slots would be miscounted
    assign bclk_rise  = bclk_d & ~bclk_prev_q;
    assign cur_active = rx_slot_enable_mask_q[slot_d];
    assign last_bit   = (bit_d == SLOT_BITS[4:0] - 5'h01);

    // Frame sync high at a bit clock edge marks slot 0, bit 0
    always @* begin
        slot_d  = slot_q;
        bit_d   = bit_q;
        shift_d = shift_q;
        if (bclk_rise) begin
            if (frame_sync_in) begin
                slot_d = 5'h00;
                bit_d  = 5'h00;
            end else if (bit_q == SLOT_BITS[4:0] - 5'h01) begin
                slot_d = slot_q + 5'h01;
                bit_d  = 5'h00;
            end else begin
                bit_d = bit_q + 5'h01;
            end
        end
    end

    // Inactive slots leave the shift register and word untouched
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bclk_prev_q   <= 1'b0;
            slot_q        <= 5'h1F;
            bit_q         <= 5'h00;
            shift_q       <= 32'h00000000;
            word_q        <= 32'h00000000;
            word_slot_q   <= 5'h00;
            word_valid_q  <= 1'b0;
            slot_active_q <= 1'b0;
        end else begin
            bclk_prev_q  <= bclk_d;
            slot_q       <= slot_d;
            bit_q        <= bit_d;
            word_valid_q <= 1'b0;
            if (bclk_rise)
                slot_active_q <= cur_active;
            if (bclk_rise && cur_active) begin
                shift_q <= {shift_d[30:0], serial_data_in};
                if (last_bit) begin
                    word_q       <= {shift_d[30:0], serial_data_in};
                    word_slot_q  <= slot_d;
                    word_valid_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output comes straight from a flop, so pins never glitch
    // while the selects or ratios are being rewritten
    assign reg_rdata_out               = rdata_q;
    assign rx_hf_master_clock_out      = hf_out_q;
    assign rx_hf_master_clock_oe_n_out = hf_oe_n_q;
    assign rx_bit_clock_out            = bclk_out_q;
    assign rx_bit_clock_oe_n_out       = bclk_oe_n_q;
    assign rx_word_out                 = word_q;
    assign rx_word_slot_out            = word_slot_q;
    assign rx_word_valid_out           = word_valid_q;
    assign rx_slot_active_bit_out      = slot_active_q;

endmodule // rx_hf_clock_and_slot_select

`default_nettype wire

// ### verification/codec_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Far-side codec: source clocks and one serial frame per request
// ----------------------------------------------------------------
module codec_model (
    // Clock and request
    input  wire logic         core_clk_in,
    input  wire logic         run_in,
    input  wire logic [127:0] frame_in,
    // Pins toward the block
    output logic              aux_clk_out,
    output logic              hf_clk_out,
    output logic              bclk_out,
    output logic              fsync_out,
    output logic              sdata_out,
    output logic              busy_out
);
    int cyc = 0;
    int ph  = 0;
    initial {aux_clk_out, hf_clk_out, bclk_out, fsync_out, sdata_out, busy_out} = 6'h00;
    // Free running sources, periods of 8 and 12 core cycles
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        aux_clk_out <= (cyc % 8) < 4;
        hf_clk_out <= (cyc % 12) < 6;
    end
    // Bit clock stands low between frames; data moves at the fall so it is steady at the rise
    always @(posedge core_clk_in) begin
        if (!busy_out) begin
            busy_out <= run_in;
            fsync_out <= run_in;
            bclk_out <= 1'b0;
            ph <= 0;
            sdata_out <= run_in ? frame_in[127] : ~sdata_out; // Idle line never shows a stale bit
        end else begin
            ph <= ph + 1;
            bclk_out <= (ph % 8) < 4;
            if (ph % 8 == 4) begin
                fsync_out <= 1'b0;
                if (ph / 8 == 127) busy_out <= 1'b0;
                sdata_out <= (ph / 8 == 127) ? ~sdata_out : frame_in[126 - ph / 8];
            end
        end
    end
endmodule // codec_model
`default_nettype wire

// ### verification/rx_hf_clock_and_slot_select_props.sv
`timescale 1ns/10ps
`default_nettype none
module rx_hf_props #(
    parameter SLOT_BITS = 32
) (
    // Clock and reset
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    // Register port
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // Clock pins
    input wire logic        auxiliary_source_clock_in,
    input wire logic        rx_hf_master_clock_in,
    input wire logic        rx_hf_master_clock_out,
    input wire logic        rx_hf_master_clock_oe_n_out,
    input wire logic        rx_bit_clock_out,
    input wire logic        rx_bit_clock_oe_n_out,
    // Received words
    input wire logic [4:0]  rx_word_slot_out,
    input wire logic        rx_word_valid_out
);
    logic [31:0] ctrl_q;
    logic [31:0] mask_q;
    logic [31:0] bit_q;
    logic [3:0]  quiet_q;
    wire logic   byp;
    // Shadow copies of the registers; quiet_q counts cycles since the last write
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= 32'h00008000;
            mask_q <= 32'h00000000;
            bit_q <= 32'h00000000;
            quiet_q <= 4'h0;
        end else begin
            quiet_q <= reg_wr_in ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
            if (reg_wr_in && reg_addr_in == 8'h00) ctrl_q <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == 8'h04) mask_q <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == 8'h08) bit_q <= reg_wdata_in;
        end
    end
    // External high clock straight through to the bit clock pin
    assign byp = quiet_q > 4'h4 && !ctrl_q[15] && bit_q[5] && bit_q[4:0] == 5'h00;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence word_pulse;
        rx_word_valid_out ##1 !rx_word_valid_out;
    endsequence
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0) else $error("read data not idle");
    reserved_zero_a: assert property (reg_rd_in && reg_addr_in == 8'h00 |=> (reg_rdata_out & 32'hFFFF3000) == 32'h0) else $error("reserved bits set");
    mask_read_a: assert property (reg_rd_in && reg_addr_in == 8'h04 |=> reg_rdata_out == mask_q) else $error("mask readback");
    hf_source_a: assert property (quiet_q > 4'h3 |-> rx_hf_master_clock_oe_n_out == !ctrl_q[15]) else $error("hf source select");
    bit_source_a: assert property (quiet_q > 4'h3 |-> rx_bit_clock_oe_n_out == !bit_q[5]) else $error("bit clock source");
    hf_bypass_a: assert property ((quiet_q > 4'h4 && ctrl_q[11:0] == 12'h000 && $stable(auxiliary_source_clock_in)) [*3] |-> rx_hf_master_clock_out == auxiliary_source_clock_in) else $error("hf divide by one");
    bit_passthru_a: assert property ((byp && $stable(rx_hf_master_clock_in)) [*3] |-> rx_bit_clock_out == (rx_hf_master_clock_in ^ ctrl_q[14])) else $error("bit clock pass-through");
    slot_gate_a: assert property (rx_word_valid_out |-> mask_q[rx_word_slot_out]) else $error("word from inactive slot");
    word_pulse_a: assert property ($rose(rx_word_valid_out) |-> word_pulse) else $error("valid not one cycle");
endmodule // rx_hf_props
bind rx_hf_clock_and_slot_select rx_hf_props #(.SLOT_BITS(SLOT_BITS)) props (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .auxiliary_source_clock_in(auxiliary_source_clock_in),
    .rx_hf_master_clock_in(rx_hf_master_clock_in), .rx_hf_master_clock_out(rx_hf_master_clock_out),
    .rx_hf_master_clock_oe_n_out(rx_hf_master_clock_oe_n_out), .rx_bit_clock_out(rx_bit_clock_out),
    .rx_bit_clock_oe_n_out(rx_bit_clock_oe_n_out), .rx_word_slot_out(rx_word_slot_out),
    .rx_word_valid_out(rx_word_valid_out));
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "rx_hf_consts.vh"
module testbench;
    logic core_clk_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, word, m, masks[4] = '{0, 32'hFFFFFFFF, 32'h80000001, 0};
    logic [127:0] f, frame_q = 128'h0;
    logic aux, hf_far, hf_out, hf_oe_n, hf_pin, bc_far, bc_out, bc_oe_n, bc_pin, fs, sd, busy, valid, act;
    logic [4:0] slot;
    logic [8:0] exp_q[$];
    int bad_count = 0, total_checks = 0, cyc = 0, hf_t = 0, hf_per = 0, bc_t = 0, bc_per = 0;
    int hr[5] = '{0, 2, 1, 0, 0}, br[5] = '{0, 0, 1, 3, 31};
    logic hf_prev = 1'b0, bc_prev = 1'b0;
    always #20 core_clk_in = ~core_clk_in;
    // Two-way pins: whoever is not enabled lets go
    assign hf_pin = hf_oe_n ? hf_far : hf_out;
    assign bc_pin = bc_oe_n ? bc_far : bc_out;
    rx_hf_clock_and_slot_select #(.SLOT_BITS(4)) uut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .auxiliary_source_clock_in(aux), .rx_hf_master_clock_in(hf_pin),
        .rx_hf_master_clock_out(hf_out), .rx_hf_master_clock_oe_n_out(hf_oe_n),
        .rx_bit_clock_in(bc_pin), .rx_bit_clock_out(bc_out), .rx_bit_clock_oe_n_out(bc_oe_n),
        .frame_sync_in(fs), .serial_data_in(sd), .rx_word_out(word),
        .rx_word_slot_out(slot), .rx_word_valid_out(valid), .rx_slot_active_bit_out(act));
    codec_model far (
        .core_clk_in(core_clk_in), .run_in(run), .frame_in(frame_q), .aux_clk_out(aux),
        .hf_clk_out(hf_far), .bclk_out(bc_far), .fsync_out(fs), .sdata_out(sd), .busy_out(busy));
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        total_checks++;
        if (seen !== expv) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One bus cycle, then one idle cycle so no strobe is driven twice in a step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge core_clk_in);
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge core_clk_in);
        if (!w) check(rdata, d);
        @(posedge core_clk_in);
    endtask
    // Periods of both clock outputs, in core cycles
    always @(negedge core_clk_in) begin
        cyc++;
        if (hf_out === 1'b1 && !hf_prev) hf_per = cyc - hf_t;
        if (hf_out === 1'b1 && !hf_prev) hf_t = cyc;
        if (bc_out === 1'b1 && !bc_prev) bc_per = cyc - bc_t;
        if (bc_out === 1'b1 && !bc_prev) bc_t = cyc;
        hf_prev = hf_out === 1'b1;
        bc_prev = bc_out === 1'b1;
        if (valid === 1'b1) check({slot, word[3:0]}, exp_q.size() ? exp_q.pop_front() : 9'h1FF);
    end
    // A hang is cut short well past the expected run length
    initial begin
        #(40 * 20000);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(70917));
        repeat (20) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        bus(0, `OFF_HF_CTRL, `HF_CTRL_RESET);
        bus(0, `OFF_SLOT_MASK, 32'h0);
        bus(0, `OFF_BIT_CTRL, 32'h0);
        bus(1, `OFF_HF_CTRL, 32'hFFFFFFFF);
        bus(0, `OFF_HF_CTRL, 32'h0000CFFF);
        bus(1, 8'h10, 32'hFFFFFFFF);
        bus(0, 8'h10, 32'h0);
        // Divider ratios, boundary bit ratio included; odd rows invert the high clock
        for (int i = 0; i < 5; i++) begin
            bus(1, `OFF_HF_CTRL, 32'h00008000 | ((i % 2) * 32'h4000) | hr[i]);
            bus(1, `OFF_BIT_CTRL, 32'h20 | br[i]);
            repeat (600) @(posedge core_clk_in);
            check(hf_per, 8 * (hr[i] + 1));
            check(bc_per, 8 * (hr[i] + 1) * (br[i] + 1));
            check({hf_oe_n, bc_oe_n}, 2'b00);
        end
        // External high clock, inverted, straight to the bit clock
        bus(1, `OFF_HF_CTRL, 32'h00004000);
        bus(1, `OFF_BIT_CTRL, 32'h20);
        repeat (100) @(posedge core_clk_in);
        check(bc_per, 12);
        check(hf_oe_n, 1'b1);
        bus(1, `OFF_BIT_CTRL, 32'h0);
        @(posedge core_clk_in);
        check(bc_oe_n, 1'b1);
        // Frames on the external bit clock under several slot masks
        foreach (masks[k]) begin
            m = (k == 0) ? $urandom : masks[k];
            f = {$urandom, $urandom, $urandom, $urandom};
            bus(1, `OFF_SLOT_MASK, m);
            bus(0, `OFF_SLOT_MASK, m);
            for (int n = 0; n < 32; n++) if (m[n]) exp_q.push_back({n[4:0], f[127 - 4 * n -: 4]});
            frame_q <= f;
            run <= 1'b1;
            @(posedge core_clk_in);
            run <= 1'b0;
            for (int t = 0; t < 2000 && (t < 4 || busy); t++) @(posedge core_clk_in);
            repeat (20) @(posedge core_clk_in);
            check(exp_q.size(), 0);
            check(act, m[31]);
        end
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
